// ===== lbps_pkg.sv
// Purpose: constants and types shared by the loopback and pulse shape logic
// Assumes: 50 MHz system clock, register addresses as seen on the host port
// Notes: phase timing is the nearest whole cycle count at the system clock
`default_nettype none

package lbps_pkg;

	// register addresses (serial address field)
	localparam logic [4:0] ADDR_CTRLB_CH1 = 5'h16;
	localparam logic [4:0] ADDR_CTRLB_CH2 = 5'h17;
	localparam logic [4:0] ADDR_WAVE_CH1 = 5'h18;
	localparam logic [4:0] ADDR_WAVE_CH2 = 5'h19;

	// loopback and line configuration register fields
	localparam int BIT_ALL_ONES = 7;
	localparam int BIT_FAR_LOOP = 6;
	localparam int BIT_NEAR_A = 5;
	localparam int BIT_NEAR_B = 4;
	localparam int CFG_MSB = 3;
	localparam int CFG_LSB = 0;
	localparam logic [7:0] RST_CTRLB_CH1 = 8'h02;
	localparam logic [7:0] RST_CTRLB_CH2 = 8'h0E;

	// waveform store
	localparam int UI_COUNT = 3;
	localparam int PHASES_PER_UI = 14;
	localparam int STORE_DEPTH = 42;
	localparam logic [7:0] STORE_LAST = 8'h29;
	localparam logic [7:0] STORE_RST = 8'h00;
	localparam int AMP_W = 7;
	localparam logic [6:0] FULL_POS = 7'h3F;
	localparam logic [6:0] FULL_NEG = 7'h40;

	// arbitrary waveform configuration codes
	localparam logic [3:0] CFG_ARB_E1_COAX = 4'h8;
	localparam logic [3:0] CFG_ARB_E1_PAIR = 4'h9;
	localparam logic [3:0] CFG_ARB_DSX1 = 4'hA;
	localparam logic [3:0] CFG_ARB_DS1 = 4'hB;

	// phases actually played per unit interval
	localparam logic [3:0] PH_DS1 = 4'hE;
	localparam logic [3:0] PH_DSX1 = 4'hD;
	localparam logic [3:0] PH_E1 = 4'hC;

	// timing
	localparam int CLK_PS = 20000;
	localparam int UI_DS1_PS = 648000;
	localparam int UI_E1_PS = 488000;
	localparam int PHASE_DS1_PS = 46300;
	localparam int PHASE_DSX1_PS = 49800;
	localparam int PHASE_E1_PS = 40700;
	localparam int CYC_DS1_I = (PHASE_DS1_PS + CLK_PS / 2) / CLK_PS;
	localparam int CYC_DSX1_I = (PHASE_DSX1_PS + CLK_PS / 2) / CLK_PS;
	localparam int CYC_E1_I = (PHASE_E1_PS + CLK_PS / 2) / CLK_PS;
	localparam logic [3:0] CYC_DS1 = 4'((CYC_DS1_I < 1) ? 1 : CYC_DS1_I);
	localparam logic [3:0] CYC_DSX1 = 4'((CYC_DSX1_I < 1) ? 1 : CYC_DSX1_I);
	localparam logic [3:0] CYC_E1 = 4'((CYC_E1_I < 1) ? 1 : CYC_E1_I);

	typedef enum logic [3:0] {
		MODE_STD = 4'b0001,
		MODE_DS1 = 4'b0010,
		MODE_DSX1 = 4'b0100,
		MODE_E1 = 4'b1000
	} lineMode_t;

endpackage : lbps_pkg

`default_nettype wire

// ===== shaper_if.sv
// Purpose: links a pulse shaper to its channel's waveform store
// Assumes: three lookups per cycle, one per unit interval of the mark
// Notes: store side answers combinationally
`timescale 1ns/1ps
`default_nettype none

interface shaper_if;
	logic [5:0] idx [3];
	logic [7:0] amp [3];
	modport store (input idx, output amp);
	modport shaper (output idx, input amp);
endinterface : shaper_if

`default_nettype wire

// ===== pulse_shaper.sv
// Purpose: plays out one channel's arbitrary pulse shape
// Assumes: markIn is valid at each unit interval boundary
// Notes: overlapping marks are summed and clamped to full scale
`timescale 1ns/1ps
`default_nettype none

module pulse_shaper
	import lbps_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic reset, // async reset, active high
	input wire logic ce, // clock enable
	input wire lineMode_t mode, // decoded line mode
	input wire logic markIn, // mark of the next unit interval
	shaper_if.shaper sif, // waveform store lookups
	output logic uiStart, // first cycle of a unit interval
	output logic [6:0] amplitude_q, // signed phase amplitude
	output logic overflow_q // clamp flag, high in every clamped cycle
);

	logic [3:0] cyc_q, cyc_d;
	logic [3:0] phase_q, phase_d;
	logic [2:0] hist_q, hist_d;
	logic [6:0] amplitude_d;
	logic overflow_d;
	logic [3:0] nPhases;
	logic [3:0] nCycles;
	logic [8:0] sum;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		case (mode)
			MODE_DS1:
			begin
				nPhases = PH_DS1;
				nCycles = CYC_DS1;
			end
			MODE_DSX1:
			begin
				nPhases = PH_DSX1;
				nCycles = CYC_DSX1;
			end
			MODE_E1:
			begin
				nPhases = PH_E1;
				nCycles = CYC_E1;
			end
			default:
			begin
				nPhases = PH_DS1;
				nCycles = CYC_DS1;
			end
		endcase
	end

	// hist bit k is the mark sent k intervals ago; its part comes from UI k+1
	always_comb
	begin
		for (int k = 0; k < UI_COUNT; k++)
			sif.idx[k] = 6'(k * PHASES_PER_UI) + {2'b00, phase_q};
	end

	always_comb
	begin
		sum = 9'h000;
		for (int k = 0; k < UI_COUNT; k++)
			if (hist_q[k])
				sum = sum + {{2{sif.amp[k][6]}}, sif.amp[k][6:0]};
	end

	always_comb
	begin
		cyc_d = cyc_q;
		phase_d = phase_q;
		hist_d = hist_q;
		amplitude_d = 7'h00;
		overflow_d = 1'b0;
		uiStart = 1'b0;
		if (mode == MODE_STD)
		begin
			cyc_d = 4'h0;
			phase_d = 4'h0;
			hist_d = 3'b000;
		end
		else
		begin
			uiStart = (cyc_q == 4'h0) && (phase_q == 4'h0);
			if (cyc_q == nCycles - 4'h1)
			begin
				cyc_d = 4'h0;
				if (phase_q >= nPhases - 4'h1)
				begin
					phase_d = 4'h0;
					hist_d = {hist_q[1:0], markIn};
				end
				else
					phase_d = phase_q + 4'h1;
			end
			else
				cyc_d = cyc_q + 4'h1;
			if ($signed(sum) > $signed({2'b00, FULL_POS}))
			begin
				amplitude_d = FULL_POS;
				overflow_d = 1'b1;
			end
			else if ($signed(sum) < $signed({2'b11, FULL_NEG}))
			begin
				amplitude_d = FULL_NEG;
				overflow_d = 1'b1;
			end
			else
				amplitude_d = sum[6:0];
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cyc_q <= 4'h0;
			phase_q <= 4'h0;
			hist_q <= 3'b000;
			amplitude_q <= 7'h00;
			overflow_q <= 1'b0;
		end
		else if (ce)
		begin
			cyc_q <= cyc_d;
			phase_q <= phase_d;
			hist_q <= hist_d;
			amplitude_q <= amplitude_d;
			overflow_q <= overflow_d;
		end
	end

endmodule : pulse_shaper

`default_nettype wire

// ===== line_loopback_and_pulse_shape_ctrl.sv
// Purpose: loopback, line configuration and pulse shape control, two channels
// Assumes: host port decoded elsewhere into address, RAM address and strobes
// Notes: analog driver and receiver sit outside; this steers their controls
//
// What this block does
// - loopback/config register per channel at 0x16/0x17
// - send-all-ones overrides loopback transmit data
// - bit 6 enables far-end loopback
// - bit 5 near loopback A, through jitter attenuator
// - host mode, both near loopbacks: receive outputs ones
// - bit 4 near loopback B, via driver, receiver
// - bits 3:0 line config, channel 2 resets 1110
// - arbitrary shapes only for arbitrary config codes
// - each mark spans three unit intervals
// - a space outputs zero amplitude
// - store holds 42 entries, 14 per interval
// - DS1 plays all 14 phases
// - DSX-1 plays 13 phases, ignores fourteenth
// - E1 plays 12 phases per interval
// - E1 ignores thirteenth and fourteenth phases
// - amplitude is 7-bit two's complement, MSB ignored
// - overlapping sums clamp and latch overflow
// - store access index 0x00 to 0x29
`timescale 1ns/1ps
`default_nettype none

module line_loopback_and_pulse_shape_ctrl
	import lbps_pkg::*;
#(
	parameter int CHANNELS = 2
)
(
	input wire logic clk_sys, // system clock, 50 MHz
	input wire logic reset, // async reset, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic hostMode, // device is under host control
	input wire logic [4:0] regAddr, // register address field
	input wire logic [7:0] ramAddr, // waveform store location
	input wire logic regWrite, // one-cycle write strobe
	input wire logic [7:0] regWrData, // write data
	output logic [7:0] regRdData_q, // read data, registered
	input wire logic [CHANNELS-1:0] jitterAttenEn, // attenuator enabled per channel
	input wire logic [CHANNELS-1:0] txSysData, // system transmit data, same clock
	input wire logic [CHANNELS-1:0] rxLinePos, // recovered positive pulse, pin
	input wire logic [CHANNELS-1:0] rxLineNeg, // recovered negative pulse, pin
	input wire logic [CHANNELS-1:0] overflowClear, // clears latched overflow
	output logic [CHANNELS-1:0] rxPositiveOut, // receive positive data out
	output logic [CHANNELS-1:0] rxNegativeOut, // receive negative data out
	output logic [CHANNELS-1:0] txLineMark, // mark sent to the line
	output logic [CHANNELS-1:0] nearLoopbackAEn, // near loopback A active
	output logic [CHANNELS-1:0] nearLoopbackBEn, // near loopback B active
	output logic [CHANNELS-1:0] loopThroughJitter, // loop path uses attenuator
	output logic [CHANNELS*4-1:0] lineConfigSelect, // line config per channel
	output logic [CHANNELS-1:0] arbitraryActive, // arbitrary shaper drives line
	output logic [CHANNELS*7-1:0] txAmplitude, // shaper amplitude per channel
	output logic [CHANNELS-1:0] uiStrobe, // start of each unit interval, low unless an arbitrary code is active
	output logic [CHANNELS-1:0] overflowLatched_q // latched overflow status
);

	logic [7:0] ctrlB_q [CHANNELS];
	logic [7:0] ctrlB_d [CHANNELS];
	logic [7:0] store_q [CHANNELS][STORE_DEPTH];
	logic [7:0] store_d [CHANNELS][STORE_DEPTH];
	logic [7:0] regRdData_d;
	logic [CHANNELS-1:0] overflowLatched_d;
	logic [CHANNELS-1:0] posMeta_q;
	logic [CHANNELS-1:0] posSync_q;
	logic [CHANNELS-1:0] negMeta_q;
	logic [CHANNELS-1:0] negSync_q;
	logic hostMeta_q;
	logic hostSync_q;
	logic [CHANNELS-1:0] overflowPulse;
	logic [CHANNELS-1:0] sendAllOnes;
	logic [CHANNELS-1:0] farLoop;
	logic [CHANNELS-1:0] nearA;
	logic [CHANNELS-1:0] nearB;
	logic [CHANNELS-1:0] ctrlHit;
	logic [CHANNELS-1:0] waveHit;
	lineMode_t chMode [CHANNELS];
	logic ramInRange;
	logic [5:0] ramIdx;

	assign ramInRange = (ramAddr <= STORE_LAST);
	// upper location bits are dropped only after the range check passed
	assign ramIdx = ramAddr[5:0];

	////////////////////////////////////////////////////////////////
	// address decode shared by the write and read paths
	always_comb
	begin
		for (int c = 0; c < CHANNELS; c++)
		begin
			ctrlHit[c] = (regAddr == ADDR_CTRLB_CH1 + 5'(c));
			waveHit[c] = (regAddr == ADDR_WAVE_CH1 + 5'(c)) && ramInRange;
		end
	end

	////////////////////////////////////////////////////////////////
	// register writes
	always_comb
	begin
		for (int c = 0; c < CHANNELS; c++)
		begin
			ctrlB_d[c] = ctrlB_q[c];
			for (int i = 0; i < STORE_DEPTH; i++)
				store_d[c][i] = store_q[c][i];
		end
		if (regWrite)
		begin
			for (int c = 0; c < CHANNELS; c++)
			begin
				if (ctrlHit[c])
					ctrlB_d[c] = regWrData;
				if (waveHit[c])
					store_d[c][ramIdx] = regWrData;
			end
		end
	end

	// register reads; unmapped addresses and out-of-range locations read zero
	always_comb
	begin
		// reads need no strobe; the address alone selects
		regRdData_d = 8'h00;
		for (int c = 0; c < CHANNELS; c++)
		begin
			if (ctrlHit[c])
				regRdData_d = ctrlB_q[c];
			if (waveHit[c])
				regRdData_d = store_q[c][ramIdx];
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			ctrlB_q[0] <= RST_CTRLB_CH1;
			for (int c = 1; c < CHANNELS; c++)
				ctrlB_q[c] <= RST_CTRLB_CH2;
			for (int c = 0; c < CHANNELS; c++)
				for (int i = 0; i < STORE_DEPTH; i++)
					store_q[c][i] <= STORE_RST;
			regRdData_q <= 8'h00;
		end
		else if (ce)
		begin
			for (int c = 0; c < CHANNELS; c++)
			begin
				ctrlB_q[c] <= ctrlB_d[c];
				for (int i = 0; i < STORE_DEPTH; i++)
					store_q[c][i] <= store_d[c][i];
			end
			regRdData_q <= regRdData_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// receive pins come from the line clock recovery, so synchronise first
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			posMeta_q <= '0;
			posSync_q <= '0;
			negMeta_q <= '0;
			negSync_q <= '0;
		end
		else if (ce)
		begin
			posMeta_q <= rxLinePos;
			posSync_q <= posMeta_q;
			negMeta_q <= rxLineNeg;
			negSync_q <= negMeta_q;
		end
	end

	// mode pin is static in use, yet it still crosses in through two flops
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			hostMeta_q <= 1'b0;
			hostSync_q <= 1'b0;
		end
		else if (ce)
		begin
			hostMeta_q <= hostMode;
			hostSync_q <= hostMeta_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// per-channel data paths and shapers
	for (genvar g = 0; g < CHANNELS; g++)
	begin : gCh
		shaper_if sif();
		logic [3:0] cfg;

		// both channels must share one line rate; the host keeps to that
		assign cfg = ctrlB_q[g][CFG_MSB:CFG_LSB];
		assign sendAllOnes[g] = ctrlB_q[g][BIT_ALL_ONES];
		assign farLoop[g] = ctrlB_q[g][BIT_FAR_LOOP];
		assign nearA[g] = ctrlB_q[g][BIT_NEAR_A];
		assign nearB[g] = ctrlB_q[g][BIT_NEAR_B];

		// only the four arbitrary codes switch the shaper on
		always_comb
		begin
			case (cfg)
				CFG_ARB_DS1: chMode[g] = MODE_DS1;
				CFG_ARB_DSX1: chMode[g] = MODE_DSX1;
				CFG_ARB_E1_COAX: chMode[g] = MODE_E1;
				CFG_ARB_E1_PAIR: chMode[g] = MODE_E1;
				default: chMode[g] = MODE_STD;
			endcase
		end

		// store answers the shaper's three lookups
		always_comb
		begin
			for (int k = 0; k < UI_COUNT; k++)
				if (sif.idx[k] < 6'(STORE_DEPTH))
					sif.amp[k] = store_q[g][sif.idx[k]];
				else
					sif.amp[k] = 8'h00;
		end

		// all ones wins over far-end loopback data and normal data
		always_comb
		begin
			if (sendAllOnes[g])
				txLineMark[g] = 1'b1;
			else if (farLoop[g])
				txLineMark[g] = posSync_q[g] | negSync_q[g];
			else
				txLineMark[g] = txSysData[g];
		end

		always_comb
		begin
			if (hostSync_q && nearA[g] && nearB[g])
			begin
				rxPositiveOut[g] = 1'b1;
				rxNegativeOut[g] = 1'b1;
			end
			// near loopback A is unipolar; the negative rail stays low
			else if (nearA[g])
			begin
				rxPositiveOut[g] = txSysData[g];
				rxNegativeOut[g] = 1'b0;
			end
			else
			begin
				rxPositiveOut[g] = posSync_q[g];
				rxNegativeOut[g] = negSync_q[g];
			end
		end

		assign nearLoopbackAEn[g] = nearA[g];
		assign nearLoopbackBEn[g] = nearB[g];
		assign loopThroughJitter[g] = (nearA[g] | nearB[g]) & jitterAttenEn[g];
		assign lineConfigSelect[g*4 +: 4] = cfg;
		assign arbitraryActive[g] = (chMode[g] != MODE_STD);

		pulse_shaper pulse_shaper_i (
			.clk_sys(clk_sys),
			.reset(reset),
			.ce(ce),
			.mode(chMode[g]),
			.markIn(txLineMark[g]),
			.sif(sif),
			.uiStart(uiStrobe[g]),
			.amplitude_q(txAmplitude[g*7 +: 7]),
			.overflow_q(overflowPulse[g])
		);
	end

	////////////////////////////////////////////////////////////////
	// overflow stays latched until cleared; a new clamp beats the clear
	always_comb
	begin
		for (int c = 0; c < CHANNELS; c++)
		begin
			overflowLatched_d[c] = overflowLatched_q[c];
			if (overflowClear[c])
				overflowLatched_d[c] = 1'b0;
			if (overflowPulse[c])
				overflowLatched_d[c] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			overflowLatched_q <= '0;
		else if (ce)
			overflowLatched_q <= overflowLatched_d;
	end

endmodule : line_loopback_and_pulse_shape_ctrl

`default_nettype wire

// ===== far_line_model.sv
// Purpose: far end of the line, sends bipolar marks into the receiver pins
// Assumes: marks alternate polarity, spaces leave both pins low
// Notes: changes on the falling edge, clear of the sampling edge
`timescale 1ns/1ps
`default_nettype none

module far_line_model
(
	input wire logic clk_sys, // clock
	input wire logic [1:0] sendMark, // mark request per channel
	output logic [1:0] linePos, // positive pulse pin
	output logic [1:0] lineNeg // negative pulse pin
);
	logic [1:0] polarity_q = 2'h0;
	initial linePos = 2'h0;
	initial lineNeg = 2'h0;
	// alternating polarity so both pins take part in far loopback
	always @(negedge clk_sys)
	begin
		polarity_q <= polarity_q ^ sendMark;
		linePos <= sendMark & ~polarity_q;
		lineNeg <= sendMark & polarity_q;
	end
endmodule : far_line_model

`default_nettype wire

// ===== line_ctrl_checker.sv
// Purpose: port checks for the loopback and pulse shape control
// Assumes: channel 1 carries the arbitrary traffic
// Notes: ce held high whenever an arbitrary code is active
`timescale 1ns/1ps
`default_nettype none

module line_ctrl_checker
	import lbps_pkg::*;
#(
	parameter int CHANNELS = 2
)
(
	input wire logic clk_sys, // clock
	input wire logic reset, // reset
	input wire logic ce, // enable
	input wire logic hostMode, // host mode
	input wire logic [4:0] regAddr, // address
	input wire logic [7:0] ramAddr, // store index
	input wire logic regWrite, // strobe
	input wire logic [7:0] regWrData, // data
	input wire logic [7:0] regRdData_q, // read data
	input wire logic [CHANNELS-1:0] jitterAttenEn, // attenuator
	input wire logic [CHANNELS-1:0] rxPositiveOut, // rx pos
	input wire logic [CHANNELS-1:0] rxNegativeOut, // rx neg
	input wire logic [CHANNELS-1:0] txLineMark, // tx mark
	input wire logic [CHANNELS-1:0] nearLoopbackAEn, // loop a
	input wire logic [CHANNELS-1:0] nearLoopbackBEn, // loop b
	input wire logic [CHANNELS-1:0] loopThroughJitter, // via attenuator
	input wire logic [CHANNELS*4-1:0] lineConfigSelect, // config
	input wire logic [CHANNELS-1:0] arbitraryActive, // shaper on
	input wire logic [CHANNELS*7-1:0] txAmplitude, // amplitude
	input wire logic [CHANNELS-1:0] uiStrobe // interval start
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	sequence s_wrCh1;
		ce && regWrite && regAddr == ADDR_CTRLB_CH1;
	endsequence
	sequence s_ds1Ui;
		uiStrobe[0] && lineConfigSelect[3:0] == CFG_ARB_DS1;
	endsequence
	property p_wrCfg;
		s_wrCh1 |=> lineConfigSelect[3:0] == $past(regWrData[3:0]);
	endproperty
	a_wrCfg: assert property (p_wrCfg) else $error("config field not written");
	property p_allOnes;
		s_wrCh1 ##0 regWrData[7] |=> txLineMark[0];
	endproperty
	a_allOnes: assert property (p_allOnes) else $error("all ones not sent");
	property p_nearBits;
		s_wrCh1 |=> {nearLoopbackAEn[0], nearLoopbackBEn[0]} == $past(regWrData[5:4]);
	endproperty
	a_nearBits: assert property (p_nearBits) else $error("near loop bits wrong");
	property p_jitter;
		loopThroughJitter == ((nearLoopbackAEn | nearLoopbackBEn) & jitterAttenEn);
	endproperty
	a_jitter: assert property (p_jitter) else $error("attenuator path wrong");
	property p_rxOnes;
		$past(hostMode, 2) && $past(ce) && $past(ce, 2)
			&& nearLoopbackAEn[0] && nearLoopbackBEn[0]
			|-> rxPositiveOut[0] && rxNegativeOut[0];
	endproperty
	a_rxOnes: assert property (p_rxOnes) else $error("receive ones missing");
	property p_arb;
		arbitraryActive[0] == (lineConfigSelect[3:2] == 2'b10);
	endproperty
	a_arb: assert property (p_arb) else $error("arbitrary decode wrong");
	property p_stdZero;
		!arbitraryActive[0] ##1 !arbitraryActive[0] |-> txAmplitude[6:0] == 7'h00;
	endproperty
	a_stdZero: assert property (p_stdZero) else $error("amplitude in standard mode");
	property p_rdGap;
		ce && regAddr == ADDR_WAVE_CH1 && ramAddr > STORE_LAST |=> regRdData_q == 8'h00;
	endproperty
	a_rdGap: assert property (p_rdGap) else $error("out of range read not zero");
	property p_uiDs1;
		s_ds1Ui |-> ##1 !uiStrobe[0] ##27 (uiStrobe[0] || lineConfigSelect[3:0] != CFG_ARB_DS1);
	endproperty
	a_uiDs1: assert property (p_uiDs1) else $error("DS1 interval length wrong");
	property p_uiE1;
		uiStrobe[0] && lineConfigSelect[3:0] == CFG_ARB_E1_PAIR |-> ##24
			(uiStrobe[0] || lineConfigSelect[3:0] != CFG_ARB_E1_PAIR);
	endproperty
	a_uiE1: assert property (p_uiE1) else $error("E1 interval length wrong");
endmodule : line_ctrl_checker

bind line_loopback_and_pulse_shape_ctrl line_ctrl_checker #(.CHANNELS(CHANNELS)) line_ctrl_checker_i (
	.clk_sys(clk_sys), .reset(reset), .ce(ce), .hostMode(hostMode), .regAddr(regAddr),
	.ramAddr(ramAddr), .regWrite(regWrite), .regWrData(regWrData), .regRdData_q(regRdData_q),
	.jitterAttenEn(jitterAttenEn), .rxPositiveOut(rxPositiveOut), .rxNegativeOut(rxNegativeOut),
	.txLineMark(txLineMark), .nearLoopbackAEn(nearLoopbackAEn), .nearLoopbackBEn(nearLoopbackBEn),
	.loopThroughJitter(loopThroughJitter), .lineConfigSelect(lineConfigSelect),
	.arbitraryActive(arbitraryActive), .txAmplitude(txAmplitude), .uiStrobe(uiStrobe));

`default_nettype wire

// ===== line_loopback_and_pulse_shape_ctrl_bench.sv
// Purpose: register, loopback and shaper checks through the register port
// Assumes: inputs change on the falling edge only
// Notes: store sums to 14 per phase with marks back to back
`timescale 1ns/1ps
`default_nettype none

module line_loopback_and_pulse_shape_ctrl_bench
	import lbps_pkg::*;
;
	logic clk_sys = 1'b0, reset = 1'b1, ce = 1'b1, hostMode = 1'b0, regWrite = 1'b0;
	logic [4:0] regAddr = 5'h00;
	logic [7:0] ramAddr = 8'h00, regWrData = 8'h00, regRdData_q;
	logic [1:0] jitterAttenEn = 2'h0, txSysData = 2'h0, overflowClear = 2'h0, sendMark = 2'h0;
	logic [1:0] rxLinePos, rxLineNeg, rxPositiveOut, rxNegativeOut, txLineMark;
	logic [1:0] nearA, nearB, viaJitter, arbOn, uiStrobe, overflowLatched_q;
	logic [7:0] lineConfigSelect;
	logic [13:0] txAmplitude;
	logic [3:0] codes [4] = '{CFG_ARB_DS1, CFG_ARB_DSX1, CFG_ARB_E1_PAIR, CFG_ARB_E1_COAX};
	int per [4] = '{28, 26, 24, 24};
	int bad_count = 0, checks = 0, n;
	always #10 clk_sys = ~clk_sys;
	line_loopback_and_pulse_shape_ctrl line_loopback_and_pulse_shape_ctrl_i (.clk_sys(clk_sys),
		.reset(reset), .ce(ce), .hostMode(hostMode), .regAddr(regAddr), .ramAddr(ramAddr),
		.regWrite(regWrite), .regWrData(regWrData), .regRdData_q(regRdData_q),
		.jitterAttenEn(jitterAttenEn), .txSysData(txSysData), .rxLinePos(rxLinePos),
		.rxLineNeg(rxLineNeg), .overflowClear(overflowClear), .rxPositiveOut(rxPositiveOut),
		.rxNegativeOut(rxNegativeOut), .txLineMark(txLineMark), .nearLoopbackAEn(nearA),
		.nearLoopbackBEn(nearB), .loopThroughJitter(viaJitter), .lineConfigSelect(lineConfigSelect),
		.arbitraryActive(arbOn), .txAmplitude(txAmplitude), .uiStrobe(uiStrobe),
		.overflowLatched_q(overflowLatched_q));
	far_line_model far_line_model_i (.clk_sys(clk_sys), .sendMark(sendMark), .linePos(rxLinePos),
		.lineNeg(rxLineNeg));
	////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("mismatches %0d comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [7:0] r, input logic [7:0] d);
		@(negedge clk_sys);
		{regAddr, ramAddr, regWrData, regWrite} = {a, r, d, 1'b1};
		@(negedge clk_sys);
		regWrite = 1'b0;
	endtask : wr
	task rd(input logic [4:0] a, input logic [7:0] r, input logic [7:0] exp);
		@(negedge clk_sys);
		{regAddr, ramAddr} = {a, r};
		@(negedge clk_sys);
		chk(regRdData_q, exp);
	endtask : rd
	// sets n to the cycles waited until the next interval start
	task waitUi;
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while (uiStrobe[0] !== 1'b1 && n < 200);
		if (n >= 200)
		begin
			bad_count++;
			end_of_test();
		end
	endtask : waitUi
	task cycles(input int c);
		repeat (c) @(negedge clk_sys);
	endtask : cycles
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		rd(ADDR_CTRLB_CH1, 8'h00, 8'h02);
		rd(ADDR_CTRLB_CH2, 8'h00, 8'h0E);
		rd(5'h10, 8'h00, 8'h00);
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h35);
		rd(ADDR_CTRLB_CH1, 8'h00, 8'h35);
		chk({6'h00, rxPositiveOut[0], rxNegativeOut[0]}, 8'h00);
		txSysData = 2'h3;
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h40);
		sendMark = 2'h1;
		cycles(4);
		chk({7'h00, txLineMark[0]}, 8'h01);
		sendMark = 2'h0;
		cycles(4);
		chk({7'h00, txLineMark[0]}, 8'h00);
		wr(ADDR_CTRLB_CH1, 8'h00, 8'hC0);
		chk({7'h00, txLineMark[0]}, 8'h01);
		jitterAttenEn = 2'h1;
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h20);
		chk({5'h00, viaJitter[0], rxPositiveOut[0], rxNegativeOut[0]}, 8'h06);
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h10);
		chk({7'h00, viaJitter[0]}, 8'h01);
		hostMode = 1'b1;
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h30);
		chk({6'h00, rxPositiveOut[0], rxNegativeOut[0]}, 8'h03);
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h02);
		ce = 1'b0;
		wr(ADDR_CTRLB_CH1, 8'h00, 8'hFF);
		ce = 1'b1;
		rd(ADDR_CTRLB_CH1, 8'h00, 8'h02);
		// the whole shape goes in before any arbitrary code
		for (int i = 0; i < STORE_DEPTH; i++)
			wr(ADDR_WAVE_CH1, 8'(i), (i < 14) ? 8'h8A : (i < 28) ? 8'h05 : 8'h7F);
		rd(ADDR_WAVE_CH1, STORE_LAST, 8'h7F);
		rd(ADDR_WAVE_CH1, 8'h00, 8'h8A);
		wr(ADDR_WAVE_CH1, 8'h2A, 8'h55);
		rd(ADDR_WAVE_CH1, 8'h2A, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			wr(ADDR_CTRLB_CH2, 8'h00, {4'h0, codes[k]});
			wr(ADDR_CTRLB_CH1, 8'h00, {4'h0, codes[k]});
			waitUi();
			waitUi();
			chk(8'(n), 8'(per[k]));
			repeat (3) waitUi();
			cycles(5);
			chk({1'b0, txAmplitude[6:0]}, 8'h0E);
		end
		txSysData = 2'h0;
		repeat (4) waitUi();
		chk({1'b0, txAmplitude[6:0]}, 8'h00);
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h02);
		wr(ADDR_WAVE_CH1, 8'h00, 8'h3F);
		txSysData = 2'h3;
		wr(ADDR_CTRLB_CH1, 8'h00, {4'h0, CFG_ARB_DS1});
		repeat (5) waitUi();
		chk({7'h00, overflowLatched_q[0]}, 8'h01);
		wr(ADDR_CTRLB_CH1, 8'h00, 8'h02);
		cycles(2);
		chk({1'b0, txAmplitude[6:0]}, 8'h00);
		overflowClear = 2'h3;
		cycles(1);
		overflowClear = 2'h0;
		cycles(1);
		chk({7'h00, overflowLatched_q[0]}, 8'h00);
		end_of_test();
	end
endmodule : line_loopback_and_pulse_shape_ctrl_bench

`default_nettype wire
